// ==== core/parmu_pkg.sv ====
// Operation
// - 16-bit virtual in, 22-bit physical out
// - eight 8KB pages, each relocated independently
// - virtual bits 15:13 pick the page
// - virtual bits 12:0 form in-page offset
// - base register gives page start address
// - descriptor gives access, length, expansion direction
// - page registers and status mapped in I/O page
// - top virtual page may reach I/O page
// - kernel, supervisor, user own separate page sets
// - kernel mode runs every instruction
// - user mode refuses halt and bus reset
// - supervisor restricted like user, own registers
// - writes allowed only where page permits
// - split I/D adds second set per mode
// - six spaces from mode and I/D choice
// - I/O page address raises dedicated indication
package parmu_pkg;
	localparam int VA_W = 16;
	localparam int PA_W = 22;
	localparam int PAGE_N = 8;
	localparam int OFS_W = 13;
	localparam int SPACE_N = 6;
	localparam int REG_N = SPACE_N * PAGE_N;
	// wishbone word offsets
	localparam logic [7:0] ADR_BASE0 = 8'h00;
	localparam logic [7:0] ADR_DESC0 = 8'h30;
	localparam logic [7:0] ADR_CTRL = 8'h60;
	localparam logic [7:0] ADR_FAULT = 8'h61;
	localparam logic [7:0] ADR_FVA = 8'h62;
	localparam logic [7:0] ADR_IRQST = 8'h63;
	localparam logic [7:0] ADR_IRQMSK = 8'h64;
	localparam logic [7:0] ADR_PRIV = 8'h65;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [PA_W-1:0] IOPAGE_START = 22'h3FE000;
	// descriptor fields
	localparam int D_ACC_LSB = 1;
	localparam int D_DIR_BIT = 3;
	localparam int D_LEN_LSB = 8;
	localparam logic [1:0] ACC_NONE = 2'h0;
	localparam logic [1:0] ACC_RO = 2'h1;
	localparam logic [1:0] ACC_RW = 2'h3;
	localparam logic [1:0] MODE_KERNEL = 2'h0;
	localparam logic [1:0] MODE_SUPER = 2'h1;
	localparam logic [1:0] MODE_USER = 2'h3;
	typedef struct packed {
		logic [VA_W-1:0] va;
		logic [1:0] mode;
		logic isInstr;
		logic write;
		logic valid;
		logic privOp;
	} parmu_req_t;
	typedef struct packed {
		logic [PA_W-1:0] pa;
		logic ioPage;
		logic abort;
		logic valid;
		logic privRefuse;
	} parmu_rsp_t;
endpackage : parmu_pkg

// ==== core/parmu_unit.sv ====
`timescale 1ns/10ps
`default_nettype none
module parmu_unit (
	input wire logic clk,
	input wire logic rst_b,
	input wire parmu_pkg::parmu_req_t req,
	output parmu_pkg::parmu_rsp_t rsp,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq
);
	import parmu_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [15:0] pageBase [REG_N];
	logic [15:0] pageDesc [REG_N];
	logic mmuEnable;
	logic splitId;
	logic [2:0] faultCode;
	logic [15:0] faultVa;
	logic [2:0] irqStatus;
	logic [2:0] irqMask;
	logic wbHit;
	logic wbWr;
	logic [2:0] spaceIdx;
	logic [5:0] regIdx;
	logic [5:0] busIdx;
	logic [15:0] selBase;
	logic [15:0] selDesc;
	logic [PA_W-1:0] physAddr;
	logic [6:0] blockNum;
	logic lenFault;
	logic accFault;
	logic refuseOp;
	logic [2:0] evt;

	assign wbHit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wbWr = wbHit & wb_we_i & wb_sel_i[0] & wb_sel_i[1];

	////////////////////////////////////////////////////////////////////////
	// space = 0/2/4 for kernel/super/user, +1 for data; D side only when split is on
	always_comb begin
		unique case (req.mode)
			MODE_KERNEL: spaceIdx = 3'h0;
			MODE_SUPER: spaceIdx = 3'h2;
			default: spaceIdx = 3'h4;
		endcase
		if (splitId && !req.isInstr) begin
			spaceIdx = spaceIdx + 3'h1;
		end
	end
	assign regIdx = {spaceIdx, req.va[15:13]};
	assign selBase = pageBase[regIdx];
	assign selDesc = pageDesc[regIdx];
	assign blockNum = req.va[12:6];

	// base counts 64-byte blocks, offset added in full
	always_comb begin
		if (mmuEnable) begin
			physAddr = {selBase, 6'h00} + {9'h000, req.va[OFS_W-1:0]};
		end else begin
			physAddr = (req.va[15:13] == 3'h7) ? {6'h3F, req.va} : {6'h00, req.va};
		end
	end

	// expand-down pages start at length block, expand-up end there
	always_comb begin
		if (selDesc[D_DIR_BIT]) begin
			lenFault = blockNum < selDesc[D_LEN_LSB +: 7];
		end else begin
			lenFault = blockNum > selDesc[D_LEN_LSB +: 7];
		end
		unique case (selDesc[D_ACC_LSB +: 2])
			ACC_RW: accFault = 1'b0;
			ACC_RO: accFault = req.write;
			default: accFault = 1'b1;
		endcase
	end
	assign refuseOp = req.valid & req.privOp & (req.mode != MODE_KERNEL);
	assign evt = {refuseOp, req.valid & mmuEnable & accFault, req.valid & mmuEnable & lenFault};

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rsp <= '0;
		end else begin
			rsp.pa <= physAddr;
			rsp.valid <= req.valid & ~(evt[1] | evt[0]) & ~refuseOp;
			rsp.abort <= req.valid & (evt[1] | evt[0]);
			rsp.ioPage <= req.valid & (physAddr >= IOPAGE_START);
			rsp.privRefuse <= refuseOp;
		end
	end

	// last fault kept for software
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			faultCode <= 3'h0;
			faultVa <= RST_WORD;
		end else if (req.valid && (evt != 3'h0)) begin
			faultCode <= evt;
			faultVa <= req.va;
		end
	end

	// write-one-to-clear; a new event wins over the clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irqStatus <= 3'h0;
		end else if (wbWr && wb_adr_i == ADR_IRQST) begin
			irqStatus <= (irqStatus & ~wb_dat_i[2:0]) | evt;
		end else begin
			irqStatus <= irqStatus | evt;
		end
	end
	assign irq = |(irqStatus & irqMask);

	////////////////////////////////////////////////////////////////////////
	assign busIdx = wb_adr_i[5:0];
	always_ff @(posedge clk) begin
		if (wbWr && wb_adr_i < ADR_DESC0) begin
			pageBase[busIdx] <= wb_dat_i[15:0];
		end
		if (wbWr && wb_adr_i >= ADR_DESC0 && wb_adr_i < ADR_CTRL) begin
			pageDesc[6'(wb_adr_i - ADR_DESC0)] <= wb_dat_i[15:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mmuEnable <= 1'b0;
			splitId <= 1'b0;
			irqMask <= 3'h0;
		end else if (wbWr && wb_adr_i == ADR_CTRL) begin
			mmuEnable <= wb_dat_i[0];
			splitId <= wb_dat_i[1];
		end else if (wbWr && wb_adr_i == ADR_IRQMSK) begin
			irqMask <= wb_dat_i[2:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wbHit;
			wb_dat_o <= 32'h0000_0000;
			if (wb_adr_i < ADR_DESC0) begin
				wb_dat_o <= {16'h0000, pageBase[busIdx]};
			end else if (wb_adr_i < ADR_CTRL) begin
				wb_dat_o <= {16'h0000, pageDesc[6'(wb_adr_i - ADR_DESC0)]};
			end else if (wb_adr_i == ADR_CTRL) begin
				wb_dat_o <= {30'h0, splitId, mmuEnable};
			end else if (wb_adr_i == ADR_FAULT) begin
				wb_dat_o <= {29'h0, faultCode};
			end else if (wb_adr_i == ADR_FVA) begin
				wb_dat_o <= {16'h0000, faultVa};
			end else if (wb_adr_i == ADR_IRQST) begin
				wb_dat_o <= {29'h0, irqStatus};
			end else if (wb_adr_i == ADR_IRQMSK) begin
				wb_dat_o <= {29'h0, irqMask};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_refuse;
		@(posedge clk) disable iff (!rst_b) (req.valid && req.privOp && req.mode == MODE_USER) |=> rsp.privRefuse;
	endproperty
	a_refuse: assert property (p_refuse) else $error("user privileged op not refused");
	property p_kernel;
		@(posedge clk) disable iff (!rst_b) (req.mode == MODE_KERNEL) |=> !rsp.privRefuse;
	endproperty
	a_kernel: assert property (p_kernel) else $error("kernel op refused");
	property p_super;
		@(posedge clk) disable iff (!rst_b) (req.valid && req.privOp && req.mode == MODE_SUPER) |=> rsp.privRefuse;
	endproperty
	a_super: assert property (p_super) else $error("supervisor op not refused");
	property p_ro;
		@(posedge clk) disable iff (!rst_b)
			(req.valid && mmuEnable && req.write && selDesc[2:1] == ACC_RO) |=> rsp.abort && !rsp.valid;
	endproperty
	a_ro: assert property (p_ro) else $error("write to read-only page passed");
	property p_io;
		@(posedge clk) disable iff (!rst_b) rsp.ioPage |-> rsp.pa[21:13] == 9'h1FF;
	endproperty
	a_io: assert property (p_io) else $error("io flag outside io page");
	property p_sum;
		@(posedge clk) disable iff (!rst_b)
			(req.valid && mmuEnable) |=> rsp.pa == {$past(selBase), 6'h00} + {9'h000, $past(req.va[12:0])};
	endproperty
	a_sum: assert property (p_sum) else $error("bad relocation sum");
	property p_rec;
		@(posedge clk) disable iff (!rst_b) rsp.abort |-> faultCode != 3'h0 && irqStatus[1:0] != 2'h0;
	endproperty
	a_rec: assert property (p_rec) else $error("abort not recorded");
	property p_ack;
		@(posedge clk) disable iff (!rst_b) wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack held two cycles");

	////////////////////////////////////////////////////////////////////////
	// response checks look one cycle after the reference, when rsp stands
	property p_excl;
		@(posedge clk) disable iff (!rst_b)
			rsp.abort |-> !rsp.valid;
	endproperty
	a_excl: assert property (p_excl) else $error("aborted reference also passed");
	property p_refuse_blocks;
		@(posedge clk) disable iff (!rst_b)
			rsp.privRefuse |-> !rsp.valid;
	endproperty
	a_refuse_blocks: assert property (p_refuse_blocks) else $error("refused op also passed");
	property p_len_up;
		@(posedge clk) disable iff (!rst_b)
			(req.valid && mmuEnable && !selDesc[D_DIR_BIT] && req.va[12:6] > selDesc[D_LEN_LSB +: 7]) |=> rsp.abort;
	endproperty
	a_len_up: assert property (p_len_up) else $error("reference past page end not aborted");
	property p_len_down;
		@(posedge clk) disable iff (!rst_b)
			(req.valid && mmuEnable && selDesc[D_DIR_BIT] && req.va[12:6] < selDesc[D_LEN_LSB +: 7]) |=> rsp.abort;
	endproperty
	a_len_down: assert property (p_len_down) else $error("reference below page start not aborted");
	property p_no_access;
		@(posedge clk) disable iff (!rst_b)
			(req.valid && mmuEnable && selDesc[D_ACC_LSB +: 2] == ACC_NONE) |=> rsp.abort;
	endproperty
	a_no_access: assert property (p_no_access) else $error("reference to closed page not aborted");
	property p_rw_pass;
		@(posedge clk) disable iff (!rst_b)
			(req.valid && mmuEnable && !req.privOp && selDesc[D_ACC_LSB +: 2] == ACC_RW && !selDesc[D_DIR_BIT]
				&& selDesc[D_LEN_LSB +: 7] == 7'h7F) |=> rsp.valid;
	endproperty
	a_rw_pass: assert property (p_rw_pass) else $error("open full page refused a reference");
	property p_ro_read;
		@(posedge clk) disable iff (!rst_b)
			(req.valid && mmuEnable && !req.write && !req.privOp && selDesc[D_ACC_LSB +: 2] == ACC_RO
				&& !lenFault) |=> rsp.valid;
	endproperty
	a_ro_read: assert property (p_ro_read) else $error("read of read-only page refused");
	property p_off_pass;
		@(posedge clk) disable iff (!rst_b)
			(req.valid && !mmuEnable) |=> rsp.pa[15:0] == $past(req.va);
	endproperty
	a_off_pass: assert property (p_off_pass) else $error("unmapped address bits altered");
	property p_off_top;
		@(posedge clk) disable iff (!rst_b)
			(req.valid && !mmuEnable && req.va[15:13] == 3'h7) |=> rsp.pa[21:16] == 6'h3F && rsp.ioPage;
	endproperty
	a_off_top: assert property (p_off_top) else $error("top virtual page not sent to io page");
	property p_off_low;
		@(posedge clk) disable iff (!rst_b)
			(req.valid && !mmuEnable && req.va[15:13] != 3'h7) |=> rsp.pa[21:16] == 6'h00 && !rsp.ioPage;
	endproperty
	a_off_low: assert property (p_off_low) else $error("low virtual page not identity mapped");
	property p_off_ok;
		@(posedge clk) disable iff (!rst_b)
			(req.valid && !mmuEnable && !req.privOp) |=> rsp.valid;
	endproperty
	a_off_ok: assert property (p_off_ok) else $error("reference refused while unmapped");
	property p_io_hit;
		@(posedge clk) disable iff (!rst_b)
			(rsp.valid && rsp.pa >= IOPAGE_START) |-> rsp.ioPage;
	endproperty
	a_io_hit: assert property (p_io_hit) else $error("io page address without io flag");
	property p_idle;
		@(posedge clk) disable iff (!rst_b)
			!req.valid |=> !rsp.valid && !rsp.abort && !rsp.privRefuse;
	endproperty
	a_idle: assert property (p_idle) else $error("response without reference");
	property p_space_k;
		@(posedge clk) disable iff (!rst_b)
			req.mode == MODE_KERNEL |-> spaceIdx[2:1] == 2'h0;
	endproperty
	a_space_k: assert property (p_space_k) else $error("kernel picked foreign page set");
	property p_space_s;
		@(posedge clk) disable iff (!rst_b)
			req.mode == MODE_SUPER |-> spaceIdx[2:1] == 2'h1;
	endproperty
	a_space_s: assert property (p_space_s) else $error("supervisor picked foreign page set");
	property p_split;
		@(posedge clk) disable iff (!rst_b)
			(splitId && !req.isInstr) |-> spaceIdx[0];
	endproperty
	a_split: assert property (p_split) else $error("data reference used fetch set");
	property p_unsplit;
		@(posedge clk) disable iff (!rst_b)
			(!splitId || req.isInstr) |-> !spaceIdx[0];
	endproperty
	a_unsplit: assert property (p_unsplit) else $error("data set used without split");
	property p_fault_va;
		@(posedge clk) disable iff (!rst_b)
			rsp.abort |-> faultVa == $past(req.va);
	endproperty
	a_fault_va: assert property (p_fault_va) else $error("fault address not kept");
	property p_refuse_rec;
		@(posedge clk) disable iff (!rst_b)
			rsp.privRefuse |-> faultCode[2] && irqStatus[2];
	endproperty
	a_refuse_rec: assert property (p_refuse_rec) else $error("refusal not recorded");
	property p_sticky;
		@(posedge clk) disable iff (!rst_b)
			(evt != 3'h0) |=> (irqStatus & $past(evt)) == $past(evt);
	endproperty
	a_sticky: assert property (p_sticky) else $error("event lost its status bit");
	property p_w1c;
		@(posedge clk) disable iff (!rst_b)
			(wbWr && wb_adr_i == ADR_IRQST && evt == 3'h0) |=> (irqStatus & $past(wb_dat_i[2:0])) == 3'h0;
	endproperty
	a_w1c: assert property (p_w1c) else $error("status bit not cleared by one");
	property p_irq_hold;
		@(posedge clk) disable iff (!rst_b)
			(!wbWr && evt == 3'h0) |=> $stable(irqStatus);
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("status changed without cause");
	property p_ack_rise;
		@(posedge clk) disable iff (!rst_b)
			wbHit |=> wb_ack_o;
	endproperty
	a_ack_rise: assert property (p_ack_rise) else $error("bus request not acknowledged");
	property p_ack_cause;
		@(posedge clk) disable iff (!rst_b)
			wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_ctrl_wr;
		@(posedge clk) disable iff (!rst_b)
			(wbWr && wb_adr_i == ADR_CTRL) |=> mmuEnable == $past(wb_dat_i[0]) && splitId == $past(wb_dat_i[1]);
	endproperty
	a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write not taken");
	property p_sel_refused;
		@(posedge clk) disable iff (!rst_b)
			(wbHit && wb_we_i && !(wb_sel_i[0] && wb_sel_i[1]))
				|=> $stable(mmuEnable) && $stable(splitId) && $stable(irqMask);
	endproperty
	a_sel_refused: assert property (p_sel_refused) else $error("partial write changed a register");
	property p_ctrl_rd;
		@(posedge clk) disable iff (!rst_b)
			(wbHit && !wb_we_i && wb_adr_i == ADR_CTRL) |=> wb_dat_o == {30'h0, $past(splitId), $past(mmuEnable)};
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read wrong");
	property p_base_wr;
		@(posedge clk) disable iff (!rst_b)
			(wbWr && wb_adr_i < ADR_DESC0) |=> pageBase[$past(busIdx)] == $past(wb_dat_i[15:0]);
	endproperty
	a_base_wr: assert property (p_base_wr) else $error("base register write lost");
	c_abort: cover property (@(posedge clk) disable iff (!rst_b) rsp.abort);
	c_io: cover property (@(posedge clk) disable iff (!rst_b) rsp.ioPage);
	c_split: cover property (@(posedge clk) disable iff (!rst_b) splitId && req.valid && !req.isInstr);
	c_refuse: cover property (@(posedge clk) disable iff (!rst_b) rsp.privRefuse);
	c_w1c: cover property (@(posedge clk) disable iff (!rst_b) wbWr && wb_adr_i == ADR_IRQST);
endmodule : parmu_unit
`default_nettype wire

// ==== tb/parmu_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module parmu_core_model (
	input wire logic clk,
	output parmu_pkg::parmu_req_t req
);
	import parmu_pkg::*;
	initial req = '0;
	// one reference per call; f is {isInstr, write, privOp}
	task automatic issue(input logic [15:0] va, input logic [1:0] mode, input logic [2:0] f);
		@(posedge clk);
		req <= '{va, mode, f[2], f[1], 1'b1, f[0]};
		@(posedge clk);
		req.valid <= 1'b0;
		// idle address lines do not keep the last value
		req.va <= ~va;
	endtask : issue
endmodule : parmu_core_model
`default_nettype wire

// ==== tb/parmu_unit_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module parmu_unit_bench;
	import parmu_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat;
	parmu_req_t req;
	parmu_rsp_t rsp;
	parmu_rsp_t rspQ[$];
	logic [31:0] rdQ[$];
	int num_errors = 0;
	int n_tests = 0;
	logic [15:0] b;
	logic [12:0] o;
	localparam parmu_rsp_t ABT = '{22'h0, 1'b0, 1'b1, 1'b0, 1'b0};
	localparam parmu_rsp_t PRV = '{22'h0, 1'b0, 1'b0, 1'b0, 1'b1};
	always #2.5 clk = ~clk;
	parmu_core_model i_core (.clk(clk), .req(req));
	parmu_unit i_dut (.clk(clk), .rst_b(rst_b), .req(req), .rsp(rsp), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq));
	////////////////////////////////////////////////////////////////////////
	function automatic parmu_rsp_t okr(input logic [21:0] a);
		return '{a, a >= IOPAGE_START, 1'b0, 1'b1, 1'b0};
	endfunction : okr
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chkRsp(input parmu_rsp_t e);
		chk("rsp flags", {28'h0, e.ioPage & e.valid, e.abort, e.valid, e.privRefuse},
			{28'h0, rsp.ioPage & rsp.valid, rsp.abort, rsp.valid, rsp.privRefuse});
		if (e.valid)
			chk("rsp pa", {10'h0, e.pa}, {10'h0, rsp.pa});
	endtask : chkRsp
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		@(posedge clk);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
		do @(posedge clk); while (ack !== 1'b1);
		{cyc, stb, we} <= 3'b000;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rdQ.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask : rd
	task automatic xl(input logic [15:0] va, input logic [1:0] m, input logic [2:0] f, input parmu_rsp_t e);
		rspQ.push_back(e);
		i_core.issue(va, m, f);
	endtask : xl
	task automatic irqIs(input logic v);
		@(negedge clk);
		chk("irq", {31'h0, v}, {31'h0, irq});
	endtask : irqIs
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if ((ack & ~we) === 1'b1)
			chk("read data", rdQ.pop_front(), rdat);
		if ((rsp.valid | rsp.abort | rsp.privRefuse) === 1'b1)
			chkRsp(rspQ.pop_front());
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_sim();
	end
	initial begin
		void'($urandom(32'hD0B3));
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		rd(ADR_CTRL, 32'h0);
		wb(1'b1, ADR_CTRL, 32'h1, 4'h0);
		rd(ADR_CTRL, 32'h0);
		rd(8'hF0, 32'h0);
		o = 13'($urandom);
		xl({3'h7, o}, MODE_KERNEL, 3'b000, okr(IOPAGE_START + 22'(o)));
		xl({3'h2, o}, MODE_USER, 3'b000, okr({9'h0, 3'h2, o}));
		wb(1'b1, ADR_CTRL, 32'h1);
		for (int p = 0; p < 8; p++) begin
			b = 16'($urandom);
			o = 13'($urandom);
			wb(1'b1, ADR_BASE0 + 8'(p), {16'h0, b});
			wb(1'b1, ADR_BASE0 + 8'(32 + p), {16'h0, ~b});
			wb(1'b1, ADR_DESC0 + 8'(p), 32'h7F06);
			wb(1'b1, ADR_DESC0 + 8'(32 + p), 32'h7F02);
			xl({3'(p), o}, MODE_KERNEL, 3'b010, okr({b, 6'h0} + 22'(o)));
			xl({3'(p), o}, MODE_USER, 3'b000, okr({~b, 6'h0} + 22'(o)));
			xl({3'(p), o}, MODE_USER, 3'b010, ABT);
		end
		rd(ADR_IRQST, 32'h2);
		irqIs(1'b0);
		wb(1'b1, ADR_IRQMSK, 32'h7);
		irqIs(1'b1);
		wb(1'b1, ADR_IRQST, 32'h2);
		irqIs(1'b0);
		// length checks in both expansion directions
		wb(1'b1, ADR_BASE0, 32'h0);
		wb(1'b1, ADR_DESC0, 32'h0006);
		xl(16'h0040, MODE_KERNEL, 3'b000, ABT);
		xl(16'h003F, MODE_KERNEL, 3'b000, okr(22'h3F));
		rd(ADR_IRQST, 32'h1);
		wb(1'b1, ADR_IRQST, 32'h1);
		wb(1'b1, ADR_DESC0, 32'h040E);
		xl(16'h00C0, MODE_KERNEL, 3'b000, ABT);
		xl(16'h0100, MODE_KERNEL, 3'b001, okr(22'h100));
		// supervisor page must be open so that only the refusal shows
		wb(1'b1, ADR_BASE0 + 8'h10, 32'h0);
		wb(1'b1, ADR_DESC0 + 8'h10, 32'h7F06);
		xl(16'h0100, MODE_SUPER, 3'b001, PRV);
		xl(16'h0100, MODE_USER, 3'b001, PRV);
		rd(ADR_IRQST, 32'h5);
		rd(ADR_FAULT, 32'h4);
		rd(ADR_FVA, 32'h100);
		rd(ADR_IRQMSK, 32'h7);
		wb(1'b1, ADR_DESC0, 32'h7F00);
		xl(16'h0000, MODE_KERNEL, 3'b000, ABT);
		rd(ADR_FAULT, 32'h2);
		// split spaces: data and fetch take different base registers
		wb(1'b1, ADR_CTRL, 32'h3);
		b = 16'($urandom);
		wb(1'b1, ADR_BASE0 + 8'h28, {16'h0, b});
		wb(1'b1, ADR_DESC0 + 8'h28, 32'h7F06);
		wb(1'b1, ADR_BASE0 + 8'h20, {16'h0, ~b});
		xl({3'h0, o}, MODE_USER, 3'b000, okr({b, 6'h0} + 22'(o)));
		xl({3'h0, o}, MODE_USER, 3'b100, okr({~b, 6'h0} + 22'(o)));
		repeat (3) @(posedge clk);
		end_sim();
	end
endmodule : parmu_unit_bench
`default_nettype wire
